/* src/bpc_map.svh */
// bpc_map.svh - offsets, field positions, reset values, codes and counts
// of the bus port command select control register bank.
// assumes: included by bare name into the modules that need it; the package does not include it.
`ifndef BPC_MAP_SVH
`define BPC_MAP_SVH

// ----------------------------------------------------------------
// register offset and layout
// ----------------------------------------------------------------
`define BPC_CTRL_OFFSET 8'h28
`define BPC_CTRL_RESET 32'h0000_0000
`define BPC_CTRL_MASK 32'h0003_FFF8
`define BPC_BIT_BURST 17
`define BPC_BIT_FORCE 16
`define BPC_BIT_MCAST 15
`define BPC_BIT_BCAST 14
`define BPC_BIT_HALT 13
`define BPC_BIT_RSVD 12
`define BPC_BIT_VQ 11
`define BPC_BIT_KILL 10
`define BPC_BIT_WRKILL 9
`define BPC_BIT_USER 8
`define BPC_BIT_IFACE 7
`define BPC_BIT_IRQ 6
`define BPC_BIT_IPI 5
`define BPC_BIT_PNXT 4
`define BPC_BIT_RTOEV 3

// ----------------------------------------------------------------
// received bus command codes
// ----------------------------------------------------------------
`define BPC_CMD_RESV0 4'h0
`define BPC_CMD_READ 4'h1
`define BPC_CMD_RDLOCK 4'h2
`define BPC_CMD_WRITE 4'h3
`define BPC_CMD_WRUNLK 4'h4
`define BPC_CMD_RDCI 4'h5
`define BPC_CMD_WRCI 4'h6
`define BPC_CMD_IPI 4'h7
`define BPC_CMD_IRQ 4'h8
`define BPC_CMD_RESV9 4'h9
`define BPC_CMD_HALT 4'hA
`define BPC_CMD_KILL 4'hB
`define BPC_CMD_BCAST 4'hC
`define BPC_CMD_VQ 4'hD

// ----------------------------------------------------------------
// event codes and retry limit
// ----------------------------------------------------------------
`define BPC_EV_RETRY_TMO 5'h1D
`define BPC_EV_RETRY_CNF 5'h01
`define BPC_RETRY_LIMIT 4096

`endif

/* src/bpc_pkg.sv */
// bpc_pkg.sv - types shared by the bus port command select control block.
// assumes: nothing; holds types only.
package bpc_pkg;

	// ----------------------------------------------------------------
	// space code classes presented with the select strobe
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		BPC_SC_NONE = 4'b0000,
		BPC_SC_MCAST = 4'b0001,
		BPC_SC_BCAST = 4'b0010,
		BPC_SC_HALT = 4'b0011,
		BPC_SC_RSVD = 4'b0100,
		BPC_SC_VQ = 4'b0101,
		BPC_SC_KILL = 4'b0110,
		BPC_SC_WRKILL = 4'b0111,
		BPC_SC_USER = 4'b1000,
		BPC_SC_IFACE = 4'b1001,
		BPC_SC_IRQ = 4'b1010,
		BPC_SC_IPI = 4'b1011
	} bpc_space_e;

	// ----------------------------------------------------------------
	// forced interprocessor interrupt sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BPC_FI_IDLE = 2'b00,
		BPC_FI_ARB = 2'b01,
		BPC_FI_SEND = 2'b10
	} bpc_fi_state_e;

endpackage

/* src/bpc_cmd_decode.sv */
// bpc_cmd_decode.sv - combinational classifier of one received command.
// assumes: command code and address flags are stable while i_cmd_valid is
// high; the caller registers the result.
`timescale 1ns/10ps
`include "bpc_map.svh"

module bpc_cmd_decode
	import bpc_pkg::*;
(
	input wire logic i_cmd_valid, // received command this cycle
	input wire logic [3:0] i_cmd_code, // received command code
	input wire logic i_addr_bcast, // address in broadcast space
	input wire logic i_addr_io, // address in i/o space
	input wire logic i_addr_mailbox, // address hits console mailbox
	input wire logic i_addr_iface, // first 256 bytes of node space
	input wire logic i_ipi_mask_match, // ipi source matches mask register
	input wire logic [31:0] i_ctrl, // control register contents
	output bpc_space_e o_class, // chosen class, none if no select
	output logic o_vq // vector query seen, any enable
);

	// read-type and write-type groups; the write group is used twice below, the read group once
	function automatic logic is_read(input logic [3:0] c);
		is_read = (c == `BPC_CMD_READ) || (c == `BPC_CMD_RDLOCK) || (c == `BPC_CMD_RDCI);
	endfunction

	function automatic logic is_write(input logic [3:0] c);
		is_write = (c == `BPC_CMD_WRITE) || (c == `BPC_CMD_WRUNLK) || (c == `BPC_CMD_WRCI);
	endfunction

	// -----------------------------------------------------------------
	// classification; a single class per command, first match wins
	// -----------------------------------------------------------------
	always_comb
	begin
		logic rw;
		rw = is_read(i_cmd_code) || is_write(i_cmd_code);
		o_class = BPC_SC_NONE;
		o_vq = i_cmd_valid && (i_cmd_code == `BPC_CMD_VQ);
		if (i_cmd_valid)
		begin
			// address classes first, then command classes
			if (rw && i_addr_bcast && i_ctrl[`BPC_BIT_MCAST])
				o_class = BPC_SC_MCAST;
			else if (rw && i_addr_iface && i_ctrl[`BPC_BIT_IFACE])
				o_class = BPC_SC_IFACE;
			else if (rw && i_addr_mailbox && i_ctrl[`BPC_BIT_USER])
				o_class = BPC_SC_USER;
			else if (is_write(i_cmd_code) && !i_addr_io && i_ctrl[`BPC_BIT_WRKILL])
				o_class = BPC_SC_WRKILL;
			else if (!rw)
			begin
				case (i_cmd_code)
					`BPC_CMD_BCAST: if (i_ctrl[`BPC_BIT_BCAST]) o_class = BPC_SC_BCAST;
					`BPC_CMD_HALT: if (i_ctrl[`BPC_BIT_HALT]) o_class = BPC_SC_HALT;
					`BPC_CMD_RESV0, `BPC_CMD_RESV9:
						if (i_ctrl[`BPC_BIT_RSVD]) o_class = BPC_SC_RSVD;
					`BPC_CMD_VQ: if (i_ctrl[`BPC_BIT_VQ]) o_class = BPC_SC_VQ;
					`BPC_CMD_KILL: if (i_ctrl[`BPC_BIT_KILL]) o_class = BPC_SC_KILL;
					`BPC_CMD_IRQ: if (i_ctrl[`BPC_BIT_IRQ]) o_class = BPC_SC_IRQ;
					`BPC_CMD_IPI:
						if (i_ipi_mask_match && i_ctrl[`BPC_BIT_IPI]) o_class = BPC_SC_IPI;
					default: o_class = BPC_SC_NONE;
				endcase
			end
		end
	end

endmodule // bpc_cmd_decode

/* src/bpc_retry_count.sv */
// bpc_retry_count.sv - counts consecutive retry answers to one transaction.
// assumes: i_retry and i_txn_end are one-cycle pulses from the master port.
`timescale 1ns/10ps
`include "bpc_map.svh"

module bpc_retry_count #(
	parameter int RETRY_LIMIT = `BPC_RETRY_LIMIT // retries before timeout
) (
	input wire logic i_core_clk, // core clock
	input wire logic i_resetn, // synchronous reset, active low
	input wire logic i_retry, // retry answer received
	input wire logic i_txn_end, // transaction ended any other way
	output logic o_timeout // one-cycle pulse on the limit-th retry
);

	localparam int CW = $clog2(RETRY_LIMIT + 1);
	localparam logic [CW-1:0] LAST = CW'(RETRY_LIMIT - 1);

	logic [CW-1:0] count_r; // retries seen so far

	// -----------------------------------------------------------------
	// consecutive count; any other ending restarts it
	// -----------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
			count_r <= '0;
		else if (i_txn_end)
			count_r <= '0;
		else if (i_retry)
			count_r <= (count_r == LAST) ? '0 : count_r + 1'b1;
	end

	// timeout pulse on the retry that reaches the limit
	assign o_timeout = i_retry && !i_txn_end && (count_r == LAST);

endmodule // bpc_retry_count

/* src/bpc_ctrl.sv */
// bpc_ctrl.sv - bus port command select control register and its logic.
// assumes: one core clock; register port, bus arbitration, command receive
// and master port pulses are synchronous to it.
`timescale 1ns/10ps
`include "bpc_map.svh"

module bpc_ctrl
	import bpc_pkg::*;
#(
	parameter int RETRY_LIMIT = `BPC_RETRY_LIMIT, // consecutive retries to timeout
	parameter logic [4:0] CNF_CODE = `BPC_EV_RETRY_CNF // retry confirmation event code
) (
	input wire logic i_core_clk, // core clock, 100 MHz
	input wire logic i_resetn, // power-fail reset, active low
	input wire logic i_reg_wr, // register write strobe
	input wire logic i_reg_rd, // register read strobe
	input wire logic [7:0] i_reg_addr, // register byte offset
	input wire logic [31:0] i_reg_wdata, // register write data
	output logic [31:0] o_reg_rdata, // register read data, one cycle late
	input wire logic i_arb_won, // pulse: this node won arbitration
	input wire logic i_master_abort, // master abort input
	output logic o_no_arb, // no-arbitration line, active high
	output logic o_ipi_arb_req, // forced ipi wants the bus
	input wire logic [15:0] i_ipi_dest, // ipi destination register
	output logic [15:0] o_ipi_dest, // destination of forced command
	input wire logic i_ipi_sent, // pulse: forced command transmitted
	input wire logic i_cmd_valid, // pulse: command received
	input wire logic [3:0] i_cmd_code, // received command code
	input wire logic i_addr_bcast, // address in broadcast space
	input wire logic i_addr_io, // address in i/o space
	input wire logic i_addr_mailbox, // address hits console mailbox
	input wire logic i_addr_iface, // address in first 256 node bytes
	input wire logic i_ipi_mask_match, // ipi matches mask register
	output logic o_sel, // port select strobe, active high
	output logic [3:0] o_space_code, // space code with select
	output logic o_vq_take_part, // take part in vector query
	input wire logic i_wr_data, // pulse: one write data longword
	input wire logic i_wr_last, // with i_wr_data: last longword
	output logic o_next_strobe, // port next strobe, active high
	input wire logic i_retry, // pulse: retry answer received
	input wire logic i_txn_end, // pulse: transaction ended otherwise
	output logic o_event_valid, // event code lines carry a code
	output logic [4:0] o_event_code, // event code lines
	output logic o_tmo_error // pulse: set retry-timeout error bit
);

	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	logic [31:0] ctrl_r; // control register
	logic burst_r; // burst hold state
	bpc_fi_state_e fi_r; // forced ipi sequencer
	logic extra_r; // extra next strobe owed
	bpc_space_e dec_class; // decoded class this cycle
	logic dec_vq; // vector query seen this cycle
	logic tmo_pulse; // retry timeout this cycle
	logic ctrl_wr; // write hits the control register
	logic force_clr; // hardware clears force bit

	assign ctrl_wr = i_reg_wr && (i_reg_addr == `BPC_CTRL_OFFSET);
	assign force_clr = (fi_r == BPC_FI_SEND) && i_ipi_sent;

	// -----------------------------------------------------------------
	// control register
	// -----------------------------------------------------------------
	// firmware loads it once; later writes still act at once, since
	// blocking them would hide a firmware fault rather than fix it
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
			ctrl_r <= `BPC_CTRL_RESET;
		else if (ctrl_wr)
		begin
			// a write that sets the force bit wins over a same-cycle clear
			ctrl_r <= i_reg_wdata & `BPC_CTRL_MASK;
			if (force_clr && !i_reg_wdata[`BPC_BIT_FORCE])
				ctrl_r[`BPC_BIT_FORCE] <= 1'b0;
		end
		else if (force_clr)
			ctrl_r[`BPC_BIT_FORCE] <= 1'b0;
	end

	// registered read; unmapped offsets read zero
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
			o_reg_rdata <= 32'h0000_0000;
		else if (i_reg_rd)
			o_reg_rdata <= (i_reg_addr == `BPC_CTRL_OFFSET) ? ctrl_r : 32'h0000_0000;
	end

	// -----------------------------------------------------------------
	// burst hold
	// -----------------------------------------------------------------
	// software keeps the burst bit clear for loopback, so no loopback
	// qualifier is carried here
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
			burst_r <= 1'b0;
		else if (!ctrl_r[`BPC_BIT_BURST] || i_master_abort)
			burst_r <= 1'b0;
		else if (i_arb_won)
			burst_r <= 1'b1;
	end

	// the line follows the hold state, registered
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
			o_no_arb <= 1'b0;
		else
			o_no_arb <= ctrl_r[`BPC_BIT_BURST] && !i_master_abort && (burst_r || i_arb_won);
	end

	// -----------------------------------------------------------------
	// forced interprocessor interrupt
	// -----------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
			fi_r <= BPC_FI_IDLE;
		else
		begin
			case (fi_r)
				BPC_FI_IDLE: // wait for software to set the force bit
					if (ctrl_r[`BPC_BIT_FORCE])
						fi_r <= BPC_FI_ARB;
				BPC_FI_ARB: // request the bus until won
					if (!ctrl_r[`BPC_BIT_FORCE])
						fi_r <= BPC_FI_IDLE;
					else if (i_arb_won)
						fi_r <= BPC_FI_SEND;
				BPC_FI_SEND: // command goes out; outcome only on events
					if (i_ipi_sent)
						fi_r <= BPC_FI_IDLE;
				default:
					fi_r <= BPC_FI_IDLE;
			endcase
		end
	end

	// bus request and destination for the forced command
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			o_ipi_arb_req <= 1'b0;
			o_ipi_dest <= 16'h0000;
		end
		else
		begin
			o_ipi_arb_req <= (fi_r == BPC_FI_IDLE) ? ctrl_r[`BPC_BIT_FORCE] :
				(fi_r == BPC_FI_ARB) && ctrl_r[`BPC_BIT_FORCE] && !i_arb_won;
			if (fi_r == BPC_FI_IDLE)
				o_ipi_dest <= i_ipi_dest;
		end
	end

	// -----------------------------------------------------------------
	// received command select
	// -----------------------------------------------------------------
	bpc_cmd_decode u_decode (
		.i_cmd_valid(i_cmd_valid),
		.i_cmd_code(i_cmd_code),
		.i_addr_bcast(i_addr_bcast),
		.i_addr_io(i_addr_io),
		.i_addr_mailbox(i_addr_mailbox),
		.i_addr_iface(i_addr_iface),
		.i_ipi_mask_match(i_ipi_mask_match),
		.i_ctrl(ctrl_r),
		.o_class(dec_class),
		.o_vq(dec_vq)
	);

	// one strobe per command, code held only with the strobe
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			o_sel <= 1'b0;
			o_space_code <= 4'h0;
			o_vq_take_part <= 1'b0;
		end
		else
		begin
			o_sel <= (dec_class != BPC_SC_NONE);
			o_space_code <= dec_class;
			o_vq_take_part <= dec_vq;
		end
	end

	// -----------------------------------------------------------------
	// next strobe for write data
	// -----------------------------------------------------------------
	// pipeline enable must track the port controller a
	// mismatch leaves the write-silo pointer one off, not detected here
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
			extra_r <= 1'b0;
		else
			extra_r <= i_wr_data && i_wr_last && ctrl_r[`BPC_BIT_PNXT];
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
			o_next_strobe <= 1'b0;
		else
			o_next_strobe <= i_wr_data || extra_r;
	end

	// -----------------------------------------------------------------
	// retry timeout event
	// -----------------------------------------------------------------
	bpc_retry_count #(
		.RETRY_LIMIT(RETRY_LIMIT)
	) u_retry (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_retry(i_retry),
		.i_txn_end(i_txn_end),
		.o_timeout(tmo_pulse)
	);

	// event code stands one cycle per timeout
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			o_event_valid <= 1'b0;
			o_event_code <= 5'h00;
			o_tmo_error <= 1'b0;
		end
		else
		begin
			o_event_valid <= tmo_pulse;
			o_tmo_error <= tmo_pulse;
			if (!tmo_pulse)
				o_event_code <= 5'h00;
			else if (ctrl_r[`BPC_BIT_RTOEV])
				o_event_code <= `BPC_EV_RETRY_TMO;
			else
				o_event_code <= CNF_CODE;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	property p_burst_hold;
		ctrl_r[`BPC_BIT_BURST] && !ctrl_wr && i_arb_won && !i_master_abort
			##1 !i_master_abort |=> o_no_arb && burst_r;
	endproperty
	a_burst_hold: assert property (p_burst_hold) else $error("burst hold not taken");

	property p_abort_keeps_bit;
		i_master_abort && !ctrl_wr |=> !o_no_arb && !burst_r
			&& (ctrl_r[`BPC_BIT_BURST] == $past(ctrl_r[`BPC_BIT_BURST]));
	endproperty
	a_abort_keeps_bit: assert property (p_abort_keeps_bit) else $error("abort misbehaved");

	property p_force_requests;
		(fi_r == BPC_FI_IDLE) && ctrl_r[`BPC_BIT_FORCE] |=> o_ipi_arb_req ##0 (fi_r == BPC_FI_ARB);
	endproperty
	a_force_requests: assert property (p_force_requests) else $error("force not requested");

	property p_force_clears;
		force_clr && !(ctrl_wr && i_reg_wdata[`BPC_BIT_FORCE]) |=> !ctrl_r[`BPC_BIT_FORCE]
			##1 !o_ipi_arb_req;
	endproperty
	a_force_clears: assert property (p_force_clears) else $error("force bit not cleared");

	property p_mcast_select;
		i_cmd_valid && i_addr_bcast && ctrl_r[`BPC_BIT_MCAST]
			&& (i_cmd_code == `BPC_CMD_READ || i_cmd_code == `BPC_CMD_WRITE)
			|=> o_sel && (o_space_code == BPC_SC_MCAST);
	endproperty
	a_mcast_select: assert property (p_mcast_select) else $error("multicast not selected");

	property p_vq_take_part;
		i_cmd_valid && (i_cmd_code == `BPC_CMD_VQ) |=> o_vq_take_part
			&& (o_sel == $past(ctrl_r[`BPC_BIT_VQ]));
	endproperty
	a_vq_take_part: assert property (p_vq_take_part) else $error("vector query mishandled");

	property p_sel_has_cause;
		o_sel |-> $past(i_cmd_valid) && (o_space_code != BPC_SC_NONE) ##1 !o_sel || $past(i_cmd_valid);
	endproperty
	a_sel_has_cause: assert property (p_sel_has_cause) else $error("select without command");

	property p_extra_next;
		i_wr_data && i_wr_last && ctrl_r[`BPC_BIT_PNXT] |=> o_next_strobe ##1 o_next_strobe;
	endproperty
	a_extra_next: assert property (p_extra_next) else $error("extra next strobe missing");

	property p_tmo_code;
		tmo_pulse && ctrl_r[`BPC_BIT_RTOEV] |=> o_event_valid
			&& (o_event_code == `BPC_EV_RETRY_TMO);
	endproperty
	a_tmo_code: assert property (p_tmo_code) else $error("timeout code wrong");

	property p_cnf_code;
		tmo_pulse && !ctrl_r[`BPC_BIT_RTOEV] |=> o_tmo_error && (o_event_code == CNF_CODE);
	endproperty
	a_cnf_code: assert property (p_cnf_code) else $error("confirmation code wrong");

	property p_reset_clear;
		$rose(i_resetn) |-> (ctrl_r == 32'h0000_0000) && !burst_r && (fi_r == BPC_FI_IDLE);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

endmodule // bpc_ctrl

/* sim/bpc_bus_node.sv */
// bpc_bus_node.sv - far-side bus model: arbitration grants and forced send.
// assumes: one core clock; requests are held until the grant pulse.
`timescale 1ns/10ps

module bpc_bus_node
(
	input wire logic i_core_clk, // core clock
	input wire logic i_resetn, // sync reset, active low
	input wire logic i_ipi_req, // forced command wants the bus
	input wire logic i_want, // bench wants the bus
	output logic o_arb_won, // grant pulse
	output logic o_ipi_sent // pulse: forced command sent
);
	logic [1:0] st_r; // 0 idle, 1 delay, 2 send, 3 release
	logic [1:0] cnt_r; // grant delay left
	logic slow_r; // alternates prompt and slow grants

	// ----------------------------------------------------------------
	// grant sequencer
	// ----------------------------------------------------------------
	// slow grants leave the request standing for several cycles
	always_ff @(posedge i_core_clk)
	begin
		o_arb_won <= 1'h0;
		o_ipi_sent <= 1'h0;
		if (!i_resetn)
		begin
			st_r <= 2'h0;
			cnt_r <= 2'h0;
			slow_r <= 1'h0;
		end
		else if (st_r == 2'h0 && (i_ipi_req || i_want))
		begin
			st_r <= 2'h1;
			cnt_r <= slow_r ? 2'h3 : 2'h0;
			slow_r <= !slow_r;
		end
		else if (st_r == 2'h1 && cnt_r != 2'h0)
			cnt_r <= cnt_r - 2'h1;
		else if (st_r == 2'h1)
		begin
			o_arb_won <= 1'h1;
			st_r <= i_ipi_req ? 2'h2 : 2'h3;
		end
		else if (st_r == 2'h2)
		begin
			o_ipi_sent <= 1'h1;
			st_r <= 2'h3;
		end
		else if (st_r == 2'h3 && !i_ipi_req && !i_want)
			st_r <= 2'h0;
	end
endmodule // bpc_bus_node

/* sim/tb_top.sv */
// tb_top.sv - self-checking bench for the command select control block.
// assumes: bpc_bus_node grants the bus; retry limit shortened to four.
`timescale 1ns/10ps
`include "bpc_map.svh"

module tb_top;
	import bpc_pkg::*;
	localparam int LIM = 4; // short retry limit keeps the run brief
	logic i_core_clk = 1'h0, i_resetn = 1'h0, rw = 1'h0, rr = 1'h0;
	logic [7:0] ra = 8'h00;
	logic [31:0] wd = 32'h0000_0000, rdat, d;
	logic arb, abt = 1'h0, noarb, ipq, sent, want = 1'h0, cv = 1'h0, pn;
	logic [15:0] dst_i = 16'h0000, dst_o, dst;
	logic [3:0] cc = 4'h0, sc, c;
	logic fb = 1'h0, fi = 1'h0, fm = 1'h0, ff = 1'h0, mm = 1'h0, m, sel, vq;
	logic wdv = 1'h0, wl = 1'h0, nxt, rt = 1'h0, te = 1'h0, evv, tmo, hit, hp;
	logic [4:0] evc;
	logic [9:0] rpat = 10'h0F7, tpat = 10'h008; // retries, one break
	int err_count = 0, comparisons = 0, cyc = 0, seed, k, f, n, i, b, cnt;
	bpc_space_e e;

	initial forever #5 i_core_clk = ~i_core_clk;

	bpc_ctrl #(.RETRY_LIMIT(LIM)) i_bpc_ctrl (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_reg_wr(rw), .i_reg_rd(rr), .i_reg_addr(ra), .i_reg_wdata(wd), .o_reg_rdata(rdat),
		.i_arb_won(arb), .i_master_abort(abt), .o_no_arb(noarb), .o_ipi_arb_req(ipq),
		.i_ipi_dest(dst_i), .o_ipi_dest(dst_o), .i_ipi_sent(sent), .i_cmd_valid(cv),
		.i_cmd_code(cc), .i_addr_bcast(fb), .i_addr_io(fi), .i_addr_mailbox(fm),
		.i_addr_iface(ff), .i_ipi_mask_match(mm), .o_sel(sel), .o_space_code(sc),
		.o_vq_take_part(vq), .i_wr_data(wdv), .i_wr_last(wl), .o_next_strobe(nxt),
		.i_retry(rt), .i_txn_end(te), .o_event_valid(evv), .o_event_code(evc),
		.o_tmo_error(tmo));
	bpc_bus_node i_bpc_bus_node (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_ipi_req(ipq), .i_want(want), .o_arb_won(arb), .o_ipi_sent(sent));

	// ----------------------------------------------------------------
	// shared tasks and reference model
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// register write holds the strobe for exactly one sampling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_core_clk);
		rw <= 1'h1;
		ra <= a;
		wd <= v;
		@(posedge i_core_clk);
		rw <= 1'h0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_core_clk);
		rr <= 1'h1;
		ra <= a;
		@(posedge i_core_clk);
		rr <= 1'h0;
		#1 chk(rdat, exp);
	endtask

	// ask the far side for the bus; ends one cycle after the grant
	task automatic grab();
		@(posedge i_core_clk);
		want <= 1'h1;
		for (k = 0; k < 20 && arb !== 1'h1; k++)
			@(posedge i_core_clk) #1;
		@(posedge i_core_clk);
		want <= 1'h0;
		#1;
	endtask

	// priority: address classes first, then command classes
	function automatic bpc_space_e exp_cls(input logic [3:0] c, input int f,
		input logic m, input logic [31:0] r);
		logic rd_t, wr_t;
		rd_t = c == `BPC_CMD_READ || c == `BPC_CMD_RDLOCK || c == `BPC_CMD_RDCI;
		wr_t = c == `BPC_CMD_WRITE || c == `BPC_CMD_WRUNLK || c == `BPC_CMD_WRCI;
		if ((rd_t || wr_t) && f == 1 && r[15]) return BPC_SC_MCAST;
		if ((rd_t || wr_t) && f == 4 && r[7]) return BPC_SC_IFACE;
		if ((rd_t || wr_t) && f == 3 && r[8]) return BPC_SC_USER;
		if (wr_t && f != 2 && r[9]) return BPC_SC_WRKILL;
		if (c == `BPC_CMD_BCAST && r[14]) return BPC_SC_BCAST;
		if ((c == `BPC_CMD_RESV0 || c == `BPC_CMD_RESV9) && r[12]) return BPC_SC_RSVD;
		if (c == `BPC_CMD_VQ && r[11]) return BPC_SC_VQ;
		if (c == `BPC_CMD_KILL && r[10]) return BPC_SC_KILL;
		if (c == `BPC_CMD_IRQ && r[6]) return BPC_SC_IRQ;
		if (c == `BPC_CMD_IPI && m && r[5]) return BPC_SC_IPI;
		return BPC_SC_NONE;
	endfunction

	// hang guard: far longer than the sequence needs
	always @(posedge i_core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		seed = 32'hd0cb_12f0;
		repeat (8) @(posedge i_core_clk);
		i_resetn <= 1'h1;
		rdchk(8'h28, 32'h0000_0000);
		rdchk(8'h40, 32'h0000_0000);
		d = $random(seed) & 32'hFFFC_FFFF; // burst and force kept clear
		wr(8'h28, d);
		wr(8'h40, 32'hFFFF_FFFF); // unmapped write is dropped
		rdchk(8'h28, d & `BPC_CTRL_MASK);
		$display("register test done");
		// random commands against random enables, halt select kept clear
		for (i = 0; i < 160; i++)
		begin
			if (i % 16 == 0)
			begin
				d = $random(seed) & 32'h0000_DFF8;
				wr(8'h28, d);
			end
			c = {$random(seed)} % 14;
			f = {$random(seed)} % 5;
			m = $random(seed);
			@(posedge i_core_clk);
			cv <= 1'h1;
			cc <= c;
			fb <= f == 1;
			fi <= f == 2;
			fm <= f == 3;
			ff <= f == 4;
			mm <= m;
			@(posedge i_core_clk);
			cv <= 1'h0;
			e = exp_cls(c, f, m, d);
			#1 chk(sel, e != BPC_SC_NONE);
			chk(sc, e);
			chk(vq, c == `BPC_CMD_VQ);
		end
		$display("select test done");
		// write transfers of one to four longwords, pipeline off and on
		for (b = 0; b < 2; b++)
		begin
			pn = b;
			wr(8'h28, {27'h0, pn, 4'h0});
			for (n = 1; n < 5; n++)
				for (i = 0; i < n + 3; i++)
				begin
					@(posedge i_core_clk);
					wdv <= i < n;
					wl <= i == n - 1;
					#1 chk(nxt, (i >= 1 && i <= n) || (pn && i == n + 1));
				end
		end
		$display("next strobe test done");
		// burst hold, abort, restart, clear; loopback never used
		wr(8'h28, 32'h0002_0000);
		grab();
		chk(noarb, 1'h1);
		repeat (5) @(posedge i_core_clk);
		#1 chk(noarb, 1'h1);
		@(posedge i_core_clk);
		abt <= 1'h1;
		@(posedge i_core_clk);
		abt <= 1'h0;
		#1 chk(noarb, 1'h0);
		rdchk(8'h28, 32'h0002_0000);
		grab();
		chk(noarb, 1'h1);
		wr(8'h28, 32'h0000_0000);
		@(posedge i_core_clk);
		#1 chk(noarb, 1'h0);
		$display("burst test done");
		// forced command, once with a prompt and once with a slow grant
		repeat (2)
		begin
			dst = $random(seed);
			@(posedge i_core_clk);
			dst_i <= dst;
			wr(8'h28, 32'h0001_0000);
			@(posedge i_core_clk);
			#1 chk(ipq, 1'h1);
			for (k = 0; k < 30 && sent !== 1'h1; k++)
				@(posedge i_core_clk) #1;
			chk(sent, 1'h1);
			chk(dst_o, dst);
			chk(ipq, 1'h0);
			rdchk(8'h28, 32'h0000_0000);
		end
		$display("forced command test done");
		// broken retry run then a full one, with each event enable state
		for (b = 0; b < 2; b++)
		begin
			wr(8'h28, b << `BPC_BIT_RTOEV);
			cnt = 0;
			hp = 1'h0;
			for (i = 0; i < 10; i++)
			begin
				@(posedge i_core_clk);
				rt <= rpat[i];
				te <= tpat[i];
				hit = rpat[i] && cnt + 1 == LIM;
				cnt = tpat[i] || hit ? 0 : cnt + rpat[i];
				#1 chk(evv, hp);
				chk(tmo, hp);
				chk(evc, hp ? (b ? `BPC_EV_RETRY_TMO : `BPC_EV_RETRY_CNF) : 5'h00);
				hp = hit;
			end
		end
		$display("retry test done");
		// mid-run reset must drop the hold and clear the register
		wr(8'h28, 32'h0002_FFF8);
		grab();
		chk(noarb, 1'h1);
		@(posedge i_core_clk);
		i_resetn <= 1'h0;
		repeat (2) @(posedge i_core_clk);
		i_resetn <= 1'h1;
		#1 chk(noarb, 1'h0);
		rdchk(8'h28, 32'h0000_0000);
		$display("reset test done");
		complete_run();
	end
endmodule // tb_top
